// [src/lbie_pkg.sv]
// Purpose: Constants and types for the logic and bit instruction executor
// Assumes: 14-bit instruction words, 8-bit data, 7-bit file addresses
// Notes:   Overview of operation
// Overview of operation
// - Opcode 00 0101 d fffffff is a one-cycle AND of accumulator and file register.
// - AND result goes to accumulator when d is 0, to the file register when 1.
// - Three-bit field picks bit 0..7; seven-bit field picks file register 0..127.
// - Opcode 01 00 clears the chosen bit, keeps other bits and flags, one cycle.
// - Opcode 01 01 sets the chosen bit, keeps other bits and flags, one cycle.
// - Opcode 01 10 tests the chosen bit; zero skips the next instruction, no flags.
// - A taken skip discards the prefetched word and runs an idle slot instead.
package lbie_pkg;
  localparam int          DATA_W         = 8;
  localparam int          ADDR_W         = 7;
  localparam int          BIT_W          = 3;
  localparam int          INSN_W         = 14;
  localparam logic [5:0]  OPC_AND_FILE   = 6'h05;
  localparam logic [3:0]  OPC_BIT_CLEAR  = 4'h4;
  localparam logic [3:0]  OPC_BIT_SET    = 4'h5;
  localparam logic [3:0]  OPC_BIT_TEST   = 4'h6;
  localparam int          DEST_POS       = 7;
  localparam int          BIT_LSB        = 7;
  localparam logic [7:0]  ACCUM_RESET    = 8'h00;

  typedef enum logic [2:0] {
    LBIE_OP_NONE  = 3'b000,
    LBIE_OP_AND   = 3'b001,
    LBIE_OP_CLEAR = 3'b010,
    LBIE_OP_SET   = 3'b011,
    LBIE_OP_TEST  = 3'b100
  } lbie_op_t;

  typedef struct packed {
    logic              we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } lbie_file_wr_t;

  typedef struct packed {
    logic [DATA_W-1:0] accum;
    logic              zero;
    logic              skip;
    lbie_file_wr_t     wr;
  } lbie_state_t;
endpackage

// [src/lbie_decode.sv]
// Purpose: Split an instruction word into operation and operand fields
// Assumes: Word is stable during the cycle it executes
// Notes:   Unsupported opcodes decode to no operation
`timescale 1ns/10ps
module lbie_decode (
  // Instruction
  input  wire logic [lbie_pkg::INSN_W-1:0] insn,
  // Decoded fields
  output lbie_pkg::lbie_op_t               op,
  output logic                             dest,
  output logic [lbie_pkg::ADDR_W-1:0]      addr,
  output logic [lbie_pkg::BIT_W-1:0]       bit_sel
);
  import lbie_pkg::*;

  assign addr    = insn[ADDR_W-1:0];
  assign bit_sel = insn[BIT_LSB+BIT_W-1:BIT_LSB];
  assign dest    = insn[DEST_POS];

  always_comb begin
    op = LBIE_OP_NONE;
    if (insn[13:8] == OPC_AND_FILE) begin
      op = LBIE_OP_AND;
    end else if (insn[13:10] == OPC_BIT_CLEAR) begin
      op = LBIE_OP_CLEAR;
    end else if (insn[13:10] == OPC_BIT_SET) begin
      op = LBIE_OP_SET;
    end else if (insn[13:10] == OPC_BIT_TEST) begin
      op = LBIE_OP_TEST;
    end
  end
endmodule // lbie_decode

// [src/lbie_exec.sv]
// Purpose: Execute AND-with-file, bit clear, bit set and bit test with skip
// Assumes: Core fetch supplies insn and file read data combinationally each cycle
// Notes:   One instruction per clock when insn_valid is high
//          A taken bit test blanks the following slot
//          Only AND with destination 0 changes the accumulator
`timescale 1ns/10ps
module lbie_exec (
  // Clock and reset
  input  wire logic                        clock,
  input  wire logic                        rst,
  // Instruction from fetch
  input  wire logic                        insn_valid,
  input  wire logic [lbie_pkg::INSN_W-1:0] insn,
  // File register read port
  output logic [lbie_pkg::ADDR_W-1:0]      file_raddr,
  input  wire logic [lbie_pkg::DATA_W-1:0] file_rdata,
  // File register write port
  output lbie_pkg::lbie_file_wr_t          file_wr,
  // Core state
  output logic [lbie_pkg::DATA_W-1:0]      accum,
  output logic                             zero_flag,
  output logic                             skip_active
);
  import lbie_pkg::*;

  lbie_op_t          op;
  logic              dest;
  logic [ADDR_W-1:0] addr;
  logic [BIT_W-1:0]  bit_sel;
  lbie_state_t       state;
  lbie_state_t       next_state;
  logic [DATA_W-1:0] and_result;
  logic [DATA_W-1:0] bit_mask;

  lbie_decode lbie_decode_i (
    .insn    (insn),
    .op      (op),
    .dest    (dest),
    .addr    (addr),
    .bit_sel (bit_sel)
  );

  assign file_raddr = addr;
  assign and_result = state.accum & file_rdata;

  // Word is executed at this edge
  logic exec_now;
  assign exec_now = insn_valid && !state.skip;

  // One-hot mask of the selected bit
  for (genvar g = 0; g < DATA_W; g++) begin : g_mask
    assign bit_mask[g] = (bit_sel == BIT_W'(g));
  end

  ////////////////////////////////////////////////////////////////////////////
  // Field layout checks
  if (INSN_W != 4 + BIT_W + ADDR_W) begin : g_bad_bit_layout
    $error("bit operation fields do not fill the instruction word");
  end
  if (INSN_W != 7 + ADDR_W) begin : g_bad_and_layout
    $error("and operation fields do not fill the instruction word");
  end
  if (DATA_W != (1 << BIT_W)) begin : g_bad_bit_index
    $error("bit index width does not match the data width");
  end
  if (DEST_POS != ADDR_W || BIT_LSB != ADDR_W) begin : g_bad_field_pos
    $error("destination or bit index field is misplaced");
  end
  if ($bits(ACCUM_RESET) != DATA_W) begin : g_bad_accum_reset
    $error("accumulator reset value has the wrong width");
  end
  if ($bits(lbie_file_wr_t) != 1 + ADDR_W + DATA_W) begin : g_bad_write_port
    $error("file write port layout is wrong");
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_state       = state;
    next_state.wr.we = 1'b0;
    next_state.skip  = 1'b0;
    if (state.skip) begin
      next_state.skip = 1'b0;
    end else if (insn_valid) begin
      unique case (op)
        LBIE_OP_AND: begin
          next_state.zero = (and_result == 8'h00);
          if (dest) begin
            next_state.wr.we   = 1'b1;
            next_state.wr.addr = addr;
            next_state.wr.data = and_result;
          end else begin
            next_state.accum = and_result;
          end
        end
        LBIE_OP_CLEAR: begin
          next_state.wr.we   = 1'b1;
          next_state.wr.addr = addr;
          next_state.wr.data = file_rdata & ~bit_mask;
        end
        LBIE_OP_SET: begin
          next_state.wr.we   = 1'b1;
          next_state.wr.addr = addr;
          next_state.wr.data = file_rdata | bit_mask;
        end
        LBIE_OP_TEST: begin
          next_state.skip = ~|(file_rdata & bit_mask);
        end
        LBIE_OP_NONE: begin
        end
      endcase
    end
  end

  // Idle state: accumulator at its reset value, no flag, no pending write
  localparam lbie_state_t STATE_RESET = '{
    accum: ACCUM_RESET,
    zero:  1'b0,
    skip:  1'b0,
    wr:    '{we: 1'b0, addr: '0, data: '0}
  };

  always_ff @(posedge clock) begin
    if (rst) begin
      state <= STATE_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign accum       = state.accum;
  assign zero_flag   = state.zero;
  assign skip_active = state.skip;
  assign file_wr     = state.wr;

  ////////////////////////////////////////////////////////////////////////////
  // Results of executed words
  a_and_zero: assert property (@(posedge clock) disable iff (rst)
    insn_valid && !state.skip && op == LBIE_OP_AND
      |=> zero_flag == (($past(accum) & $past(file_rdata)) == 8'h00))
    else $error("zero flag wrong after and");
  a_and_dest: assert property (@(posedge clock) disable iff (rst)
    insn_valid && !state.skip && op == LBIE_OP_AND && dest |=> file_wr.we && accum == $past(accum))
    else $error("and to file changed accumulator");
  a_and_accum: assert property (@(posedge clock) disable iff (rst)
    insn_valid && !state.skip && op == LBIE_OP_AND && !dest
      |=> !file_wr.we && accum == ($past(accum) & $past(file_rdata)))
    else $error("and to accumulator wrong");
  a_clear_bit: assert property (@(posedge clock) disable iff (rst)
    insn_valid && !state.skip && op == LBIE_OP_CLEAR
      |=> file_wr.we && file_wr.data == ($past(file_rdata) & ~(8'h01 << $past(bit_sel))))
    else $error("bit clear wrong");
  a_set_bit: assert property (@(posedge clock) disable iff (rst)
    insn_valid && !state.skip && op == LBIE_OP_SET
      |=> file_wr.we && file_wr.data == ($past(file_rdata) | (8'h01 << $past(bit_sel))))
    else $error("bit set wrong");
  a_bit_flags: assert property (@(posedge clock) disable iff (rst)
    insn_valid && !state.skip && op inside {LBIE_OP_CLEAR, LBIE_OP_SET, LBIE_OP_TEST}
      |=> $stable(zero_flag) && $stable(accum))
    else $error("bit op changed flags");
  a_test_skip: assert property (@(posedge clock) disable iff (rst)
    insn_valid && !state.skip && op == LBIE_OP_TEST
      |=> skip_active == !$past(file_rdata[bit_sel]))
    else $error("bit test skip wrong");
  a_skip_idle: assert property (@(posedge clock) disable iff (rst)
    skip_active |=> !skip_active && !file_wr.we && $stable(accum) && $stable(zero_flag))
    else $error("discarded word executed");
  a_write_addr: assert property (@(posedge clock) disable iff (rst)
    insn_valid && !state.skip && op inside {LBIE_OP_CLEAR, LBIE_OP_SET}
      |=> file_wr.addr == $past(insn[6:0]))
    else $error("write address wrong");
  a_and_file: assert property (@(posedge clock) disable iff (rst)
    exec_now && op == LBIE_OP_AND && dest
      |=> file_wr.addr == $past(addr)
          && file_wr.data == ($past(accum) & $past(file_rdata)))
    else $error("and to file wrote wrong word");
  a_clear_low: assert property (@(posedge clock) disable iff (rst)
    exec_now && op == LBIE_OP_CLEAR |=> !file_wr.data[$past(bit_sel)])
    else $error("cleared bit still set");
  a_set_high: assert property (@(posedge clock) disable iff (rst)
    exec_now && op == LBIE_OP_SET |=> file_wr.data[$past(bit_sel)])
    else $error("set bit still clear");
  a_mask_onehot: assert property (@(posedge clock) disable iff (rst)
    $onehot(bit_mask))
    else $error("bit mask not one-hot");
  a_raddr_follow: assert property (@(posedge clock) disable iff (rst)
    file_raddr == insn[ADDR_W-1:0])
    else $error("read address not taken from word");

  // Side effects
  a_write_cause: assert property (@(posedge clock) disable iff (rst)
    file_wr.we |-> $past(insn_valid && !skip_active && op != LBIE_OP_TEST
                         && op != LBIE_OP_NONE && !(op == LBIE_OP_AND && !dest)))
    else $error("file write without a writing instruction");
  a_zero_only_and: assert property (@(posedge clock) disable iff (rst)
    !(exec_now && op == LBIE_OP_AND) |=> $stable(zero_flag))
    else $error("zero flag changed outside and");
  a_accum_only_and: assert property (@(posedge clock) disable iff (rst)
    !(exec_now && op == LBIE_OP_AND && !dest) |=> $stable(accum))
    else $error("accumulator changed outside and");
  a_unknown_idle: assert property (@(posedge clock) disable iff (rst)
    exec_now && op == LBIE_OP_NONE
      |=> !file_wr.we && !skip_active)
    else $error("unsupported word had an effect");
  a_test_no_write: assert property (@(posedge clock) disable iff (rst)
    exec_now && op == LBIE_OP_TEST |=> !file_wr.we)
    else $error("bit test wrote a register");
  a_and_no_skip: assert property (@(posedge clock) disable iff (rst)
    exec_now && op == LBIE_OP_AND |=> !skip_active)
    else $error("and started a skip");
  a_bit_no_skip: assert property (@(posedge clock) disable iff (rst)
    exec_now && op inside {LBIE_OP_CLEAR, LBIE_OP_SET} |=> !skip_active)
    else $error("bit write started a skip");

  // Skip and reset
  a_skip_cause: assert property (@(posedge clock) disable iff (rst)
    skip_active |-> $past(insn_valid && !skip_active && op == LBIE_OP_TEST))
    else $error("skip without a bit test");
  a_reset_clear: assert property (@(posedge clock)
    rst |=> accum == ACCUM_RESET && !zero_flag && !skip_active && !file_wr.we)
    else $error("reset left state behind");

  c_skip_taken: cover property (@(posedge clock) disable iff (rst) skip_active);
  c_and_zero:   cover property (@(posedge clock) disable iff (rst)
    insn_valid && op == LBIE_OP_AND ##1 zero_flag);
  c_set_write:  cover property (@(posedge clock) disable iff (rst)
    insn_valid && !state.skip && op == LBIE_OP_SET);
  c_skip_free:  cover property (@(posedge clock) disable iff (rst)
    exec_now && op == LBIE_OP_TEST ##1 !skip_active);
  c_discard:    cover property (@(posedge clock) disable iff (rst)
    skip_active && insn_valid);
endmodule // lbie_exec

// [verification/lbie_file_model.sv]
// Purpose: Behavioural file register array seen from the core side
// Assumes: Combinational read, write on the edge after the write pulse
// Notes:   Forwards a pending write so back-to-back reads see new data
`timescale 1ns/10ps
module lbie_file_model (
  // Clock
  input  wire logic                        clock,
  // Ports facing the executor
  input  wire logic [lbie_pkg::ADDR_W-1:0] file_raddr,
  output logic [lbie_pkg::DATA_W-1:0]      file_rdata,
  input  wire lbie_pkg::lbie_file_wr_t     file_wr
);
  import lbie_pkg::*;
  logic [DATA_W-1:0] mem [128];
  initial begin
    for (int i = 0; i < 128; i++) mem[i] = 8'(2 * i + 1);
  end
  // Pending write is forwarded until it lands in the array
  assign file_rdata = (file_wr.we && file_wr.addr == file_raddr) ? file_wr.data : mem[file_raddr];
  always @(posedge clock) begin
    if (file_wr.we) mem[file_wr.addr] <= file_wr.data;
  end
endmodule // lbie_file_model

// [verification/logic_bit_instruction_exec_tb.sv]
// Purpose: Self-checking bench for the logic and bit instruction executor
// Assumes: File register i starts as 2*i+1; accumulator resets to zero
// Notes:   One task per scenario
`timescale 1ns/10ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin err_count++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module logic_bit_instruction_exec_tb;
  import lbie_pkg::*;
  logic clock = 0, rst = 1, insn_valid = 0;
  logic [INSN_W-1:0] insn = '0;
  logic [ADDR_W-1:0] file_raddr;
  logic [DATA_W-1:0] file_rdata, accum;
  logic              zero_flag, skip_active;
  lbie_file_wr_t     file_wr;
  int err_count = 0, total_checks = 0, cycles = 0;
  always #50 clock = ~clock;
  lbie_exec lbie_exec_i (.clock(clock), .rst(rst), .insn_valid(insn_valid), .insn(insn),
    .file_raddr(file_raddr), .file_rdata(file_rdata), .file_wr(file_wr), .accum(accum),
    .zero_flag(zero_flag), .skip_active(skip_active));
  lbie_file_model lbie_file_model_i (.clock(clock), .file_raddr(file_raddr),
    .file_rdata(file_rdata), .file_wr(file_wr));
  ////////////////////////////////////////////////////////////////////////////
  task automatic step(input logic v, input logic [INSN_W-1:0] w);
    @(posedge clock);
    insn_valid <= v;
    insn <= w;
  endtask
  task automatic wr_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    `CHK("we", 1'b1, file_wr.we)
    `CHK("addr", a, file_wr.addr)
    `CHK("data", d, file_wr.data)
  endtask
  task automatic and_test;
    step(1'b1, {OPC_AND_FILE, 1'b0, 7'h0a});
    #1 `CHK("raddr", 7'h0a, file_raddr)
    step(1'b0, '0);
    #1 `CHK("zero", 1'b1, zero_flag)
    `CHK("accum", 8'h00, accum)
    `CHK("no wr", 1'b0, file_wr.we)
    step(1'b1, {OPC_AND_FILE, 1'b1, 7'h05});
    step(1'b0, '0);
    #1 wr_chk(7'h05, 8'h00);
  endtask
  task automatic bit_ops;
    step(1'b1, {OPC_BIT_CLEAR, 3'h7, 7'h7f});
    step(1'b0, '0);
    #1 wr_chk(7'h7f, 8'h7f);
    `CHK("zero kept", 1'b1, zero_flag)
    step(1'b1, {OPC_BIT_SET, 3'h1, 7'h00});
    step(1'b0, '0);
    #1 wr_chk(7'h00, 8'h03);
    `CHK("zero kept", 1'b1, zero_flag)
  endtask
  task automatic skip_test(input logic [2:0] b, input logic taken);
    step(1'b1, {OPC_BIT_TEST, b, 7'h0a});
    step(1'b1, {OPC_BIT_SET, 3'h7, 7'h01});
    #1 `CHK("skip", taken, skip_active)
    `CHK("test zero kept", 1'b1, zero_flag)
    `CHK("test no wr", 1'b0, file_wr.we)
    step(1'b0, '0);
    #1 `CHK("discard", !taken, file_wr.we)
    if (!taken) wr_chk(7'h01, 8'h83);
    `CHK("skip end", 1'b0, skip_active)
  endtask
  task automatic idle_test;
    step(1'b1, {4'h7, 3'h1, 7'h0a});
    #1 `CHK("raddr", 7'h0a, file_raddr)
    step(1'b0, {OPC_AND_FILE, 1'b1, 7'h05});
    #1 `CHK("unknown no skip", 1'b0, skip_active)
    `CHK("unknown no wr", 1'b0, file_wr.we)
    step(1'b0, '0);
    #1 `CHK("invalid no wr", 1'b0, file_wr.we)
    `CHK("invalid zero", 1'b1, zero_flag)
  endtask
  task automatic reset_test;
    @(posedge clock);
    rst <= 1'b1;
    insn_valid <= 1'b1;
    insn <= {OPC_BIT_SET, 3'h1, 7'h02};
    @(posedge clock);
    rst <= 1'b0;
    insn_valid <= 1'b0;
    #1 `CHK("mid rst zero", 1'b0, zero_flag)
    `CHK("mid rst wr", 1'b0, file_wr.we)
    `CHK("mid rst accum", ACCUM_RESET, accum)
    step(1'b1, {OPC_BIT_SET, 3'h1, 7'h02});
    step(1'b0, '0);
    #1 wr_chk(7'h02, 8'h07);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 2000) begin
      err_count++;
      final_report();
    end
  end
  initial begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    #1 `CHK("rst zero", 1'b0, zero_flag)
    `CHK("rst skip", 1'b0, skip_active)
    and_test();
    bit_ops();
    skip_test(3'h1, 1'b1);
    skip_test(3'h2, 1'b0);
    idle_test();
    reset_test();
    final_report();
  end
endmodule // logic_bit_instruction_exec_tb
